// *** inc/uis_pkg.sv ***
// Package: constants and carriers of the UART interrupt, sleep and baud block
`default_nettype none
// Overview of operation
// - Seven interrupt types, each enabled separately; only enabled ones reach the pin.
// - Identification field shows highest pending type, 00 0001 when none.
// - Line status errors in receive data give priority 1, code 00 0110.
// - Receive time-out 00 1100 and data ready 00 0100 share priority 2.
// - Transmit holding empty or below trigger gives priority 3, code 00 0010.
// - Modem pin change gives 00 0000; general pin change gives 11 0000.
// - Stop or special character reception gives priority 6, code 01 0000.
// - Request or clear pin going inactive high gives priority 7, code 10 0000.
// - Error summary bit 7 follows any erroneous receive character and raises line status.
// - Status bits 4 to 2 show head character flags, zeros when receive empty.
// - Stop-character interrupt clears on resume character; special one on identification read.
// - Any enable bit 6, 5 or 3 to 0 set, or any pin enable set, means interrupt mode, else host polls.
// - Sleep allowed only with enhanced bit 4 and sleep enable bit 4 set.
// - Sleep entered only when receive idle and empty, transmit empty, nothing but transmit pending.
// - Sleep stops the channel clock; wake on line, modem change or transmit write.
// - Time-out fires four character times after last character below trigger.
// - Break detected when receive input stays low beyond one full frame.
// - Line control bit 6 forces transmit output low until cleared.
// - Sixteen-bit divisor; zero means no baud clock at all.
// - Modem control bit 7 selects prescaler divide by 1 or 4, reset 1.
// - Baud is clock over prescaler over divisor times sample rate.
// - After reset identification reads bit 0 set, others clear.
// - Divisor bytes and scratch byte keep their values through reset.
package uis_pkg;
	// Register byte offsets
	localparam logic [7:0] A_IER = 8'h00;
	localparam logic [7:0] A_IIR = 8'h04;
	localparam logic [7:0] A_LCR = 8'h08;
	localparam logic [7:0] A_MCR = 8'h0C;
	localparam logic [7:0] A_LSR = 8'h10;
	localparam logic [7:0] A_EFR = 8'h14;
	localparam logic [7:0] A_DLL = 8'h18;
	localparam logic [7:0] A_DLH = 8'h1C;
	localparam logic [7:0] A_SMP = 8'h20;
	localparam logic [7:0] A_IOEN = 8'h24;
	localparam logic [7:0] A_IOST = 8'h28;
	localparam logic [7:0] A_SPR = 8'h2C;
	// Reset values
	localparam logic [7:0] LCR_RST = 8'h1D;
	// Identification codes
	localparam logic [5:0] IIR_NONE = 6'h01;
	localparam logic [5:0] IIR_LS = 6'h06;
	localparam logic [5:0] IIR_TO = 6'h0C;
	localparam logic [5:0] IIR_RX = 6'h04;
	localparam logic [5:0] IIR_TX = 6'h02;
	localparam logic [5:0] IIR_MDM = 6'h00;
	localparam logic [5:0] IIR_IO = 6'h30;
	localparam logic [5:0] IIR_XOFF = 6'h10;
	localparam logic [5:0] IIR_RC = 6'h20;
	// Timing figures
	localparam int TO_CHARS = 4;
	localparam logic [1:0] PRE_LAST = 2'h3;
	localparam logic [5:0] SMP_BASE = 6'h10;
	// Events from the channel datapath
	typedef struct packed {
		logic rx_err_any;
		logic [2:0] head_flags;
		logic rx_overrun;
		logic rx_empty;
		logic rx_ready;
		logic rx_below_trig;
		logic rx_stop_mid;
		logic rx_read;
		logic rx_busy;
		logic tx_ready;
		logic tx_idle;
		logic tx_write;
		logic modem_delta;
		logic xoff_det;
		logic xon_det;
		logic special_det;
	} uis_evt_s;
endpackage
`default_nettype wire

// *** src/uis_core.sv ***
// Interrupt priority, sleep, break, time-out and baud generator of one channel
`default_nettype none
module uis_core (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire uis_pkg::uis_evt_s evt,
	input wire logic rx_pin,
	input wire logic rts_n,
	input wire logic cts_n,
	input wire logic [7:0] io_pins,
	output logic irq_n,
	output logic tx_force_low,
	output logic sample_tick,
	output logic bit_tick,
	output logic chan_clk_en,
	output logic break_det,
	output logic rx_timeout
);
	import uis_pkg::*;

	logic [7:0] ier_q, lcr_q, mcr_q, efr_q, smp_q, ioen_q;
	logic [7:0] dll_q, dlh_q, spr_q;
	logic [7:0] io_prev_q, io_q;
	logic ovr_q, xoff_q, spc_q, rc_q, rts_prev_q, cts_prev_q, rx_prev_q;
	logic sleep_q;
	logic [1:0] pre_q;
	logic [15:0] div_q;
	logic [5:0] scnt_q;
	logic [4:0] brk_q;
	logic [6:0] to_q;
	logic wr, rd, setup, known;
	logic [6:0] pend;
	logic [5:0] iir_v;
	logic [7:0] lsr_v;
	logic [15:0] divisor;
	logic [5:0] rate;
	logic [3:0] fbits;
	logic [6:0] to_lim;
	logic allowed, rx_idle, enter, wake, pre_en, run, div_wrap;
	logic iir_rd, lsr_rd, io_rd;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	// Bus strobes; every access completes in its first access cycle
	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign iir_rd = rd && paddr == A_IIR;
	assign lsr_rd = rd && paddr == A_LSR;
	assign io_rd = rd && paddr == A_IOST;

	// Address decode
	always_comb begin
		case (paddr)
			A_IER, A_IIR, A_LCR, A_MCR, A_LSR, A_EFR, A_DLL, A_DLH, A_SMP, A_IOEN, A_IOST, A_SPR: known = 1'b1;
			default: known = 1'b0;
		endcase
	end

	// Divisor written while asleep is refused as an error
	assign pslverr = psel && penable && (!known || (pwrite && sleep_q && (paddr == A_DLL || paddr == A_DLH)));

	// Control registers set by reset; line control loads LCR_RST, the others clear
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ier_q <= 8'h00;
			lcr_q <= LCR_RST;
			mcr_q <= 8'h00;
			efr_q <= 8'h00;
			smp_q <= 8'h00;
			ioen_q <= 8'h00;
		end else if (wr) begin
			case (paddr)
				A_IER: ier_q <= pwdata[7:0];
				A_LCR: lcr_q <= pwdata[7:0];
				A_MCR: mcr_q <= pwdata[7:0];
				A_EFR: efr_q <= pwdata[7:0];
				A_SMP: smp_q <= pwdata[7:0];
				A_IOEN: ioen_q <= pwdata[7:0];
				default: ;
			endcase
		end
	end

	// Divisor and scratch bytes survive every reset
	always_ff @(posedge core_clk) begin
		if (wr && !sleep_q && paddr == A_DLL) begin
			dll_q <= pwdata[7:0];
		end
		if (wr && !sleep_q && paddr == A_DLH) begin
			dlh_q <= pwdata[7:0];
		end
		if (wr && paddr == A_SPR) begin
			spr_q <= pwdata[7:0];
		end
	end

	// Line status view of the receive data
	always_comb begin
		lsr_v = 8'h00;
		lsr_v[7] = evt.rx_err_any;
		lsr_v[6] = evt.tx_idle;
		lsr_v[5] = evt.tx_ready;
		lsr_v[4:2] = evt.rx_empty ? 3'h0 : evt.head_flags;
		lsr_v[1] = ovr_q;
		lsr_v[0] = !evt.rx_empty;
	end

	// Read data captured in the setup cycle
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			prdata <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			case (paddr)
				A_IER: prdata <= {24'h00_0000, ier_q};
				A_IIR: prdata <= {26'h000_0000, iir_v};
				A_LCR: prdata <= {24'h00_0000, lcr_q};
				A_MCR: prdata <= {24'h00_0000, mcr_q};
				A_LSR: prdata <= {24'h00_0000, lsr_v};
				A_EFR: prdata <= {24'h00_0000, efr_q};
				A_DLL: prdata <= {24'h00_0000, dll_q};
				A_DLH: prdata <= {24'h00_0000, dlh_q};
				A_SMP: prdata <= {24'h00_0000, smp_q};
				A_IOEN: prdata <= {24'h00_0000, ioen_q};
				A_IOST: prdata <= {24'h00_0000, io_q};
				A_SPR: prdata <= {24'h00_0000, spr_q};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Sticky event flags; a new event beats a clear in the same cycle
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ovr_q <= 1'b0;
			xoff_q <= 1'b0;
			spc_q <= 1'b0;
			rc_q <= 1'b0;
			io_q <= 8'h00;
		end else begin
			ovr_q <= evt.rx_overrun || (ovr_q && !lsr_rd);
			xoff_q <= evt.xoff_det || (xoff_q && !evt.xon_det);
			spc_q <= evt.special_det || (spc_q && !iir_rd);
			rc_q <= (rts_n && !rts_prev_q) || (cts_n && !cts_prev_q) || (rc_q && !iir_rd);
			io_q <= (io_pins ^ io_prev_q) | (io_rd ? 8'h00 : io_q);
		end
	end

	// Previous pin levels for change detection
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			io_prev_q <= 8'h00;
			rts_prev_q <= 1'b1;
			cts_prev_q <= 1'b1;
			rx_prev_q <= 1'b1;
		end else begin
			io_prev_q <= io_pins;
			rts_prev_q <= rts_n;
			cts_prev_q <= cts_n;
			rx_prev_q <= rx_pin;
		end
	end

	// Enabled pending sources, index 0 is the highest priority
	always_comb begin
		pend[0] = ier_q[2] && (evt.rx_err_any || ovr_q);
		pend[1] = ier_q[0] && (rx_timeout || evt.rx_ready);
		pend[2] = ier_q[1] && evt.tx_ready;
		pend[3] = ier_q[3] && evt.modem_delta;
		pend[4] = |(io_q & ioen_q);
		pend[5] = ier_q[5] && (xoff_q || spc_q);
		pend[6] = ier_q[6] && rc_q;
	end

	// Priority encoder for the identification field
	always_comb begin
		if (pend[0]) begin
			iir_v = IIR_LS;
		end else if (pend[1]) begin
			iir_v = rx_timeout ? IIR_TO : IIR_RX;
		end else if (pend[2]) begin
			iir_v = IIR_TX;
		end else if (pend[3]) begin
			iir_v = IIR_MDM;
		end else if (pend[4]) begin
			iir_v = IIR_IO;
		end else if (pend[5]) begin
			iir_v = IIR_XOFF;
		end else if (pend[6]) begin
			iir_v = IIR_RC;
		end else begin
			iir_v = IIR_NONE;
		end
	end

	// Interrupt pin; with enable bits 6, 5 and 3 to 0 and all pin enables clear the host polls instead
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			irq_n <= 1'b1;
		end else begin
			irq_n <= !(|pend);
		end
	end

	// Break output follows line control bit 6
	assign tx_force_low = lcr_q[6];

	// Sleep entry and wake
	assign allowed = efr_q[4] && ier_q[4];
	assign rx_idle = rx_pin && !evt.rx_busy;
	assign enter = allowed && rx_idle && evt.rx_empty && evt.tx_idle && (pend & 7'h7B) == 7'h00;
	assign wake = !allowed || rx_pin != rx_prev_q || evt.modem_delta || evt.tx_write;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			sleep_q <= 1'b0;
		end else if (sleep_q) begin
			sleep_q <= !wake;
		end else begin
			sleep_q <= enter;
		end
	end
	assign chan_clk_en = !sleep_q;

	// Baud generator terms
	assign divisor = {dlh_q, dll_q};
	assign rate = SMP_BASE - {2'h0, smp_q[3:0]} + {2'h0, smp_q[7:4]};
	assign run = divisor != 16'h0000 && !sleep_q;
	assign pre_en = mcr_q[7] ? pre_q == PRE_LAST : 1'b1;
	assign div_wrap = div_q >= divisor - 16'h0001;

	// Prescaler, divisor and sample counters; one generator serves both directions
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pre_q <= 2'h0;
			div_q <= 16'h0000;
			scnt_q <= 6'h00;
			sample_tick <= 1'b0;
			bit_tick <= 1'b0;
		end else begin
			sample_tick <= 1'b0;
			bit_tick <= 1'b0;
			if (!run) begin
				pre_q <= 2'h0;
				div_q <= 16'h0000;
			end else begin
				pre_q <= pre_q + 2'h1;
				if (pre_en) begin
					div_q <= div_wrap ? 16'h0000 : div_q + 16'h0001;
					if (div_wrap) begin
						sample_tick <= 1'b1;
						scnt_q <= scnt_q + 6'h01 >= rate ? 6'h00 : scnt_q + 6'h01;
						bit_tick <= scnt_q + 6'h01 >= rate;
					end
				end
			end
		end
	end

	// Frame length in bit times: start, data, parity, stop
	assign fbits = 4'h7 + {2'h0, lcr_q[1:0]} + {3'h0, lcr_q[3]} + {3'h0, lcr_q[2]};
	assign to_lim = 7'(TO_CHARS) * {3'h0, fbits};

	// Break detection counts bit times with the line low
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			brk_q <= 5'h00;
			break_det <= 1'b0;
		end else begin
			break_det <= bit_tick && !rx_pin && brk_q == {1'b0, fbits};
			if (rx_pin) begin
				brk_q <= 5'h00;
			end else if (bit_tick && brk_q <= {1'b0, fbits}) begin
				brk_q <= brk_q + 5'h01;
			end
		end
	end

	// Receive time-out counter restarts on stop-bit centre and on reads
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			to_q <= 7'h00;
			rx_timeout <= 1'b0;
		end else begin
			if (evt.rx_stop_mid || evt.rx_read || evt.rx_empty) begin
				to_q <= 7'h00;
			end else if (bit_tick && to_q < to_lim) begin
				to_q <= to_q + 7'h01;
			end
			if (bit_tick && to_q == to_lim - 7'h01 && evt.rx_below_trig
					&& !(evt.rx_stop_mid || evt.rx_read || evt.rx_empty)) begin
				rx_timeout <= 1'b1;
			end else if (evt.rx_stop_mid || evt.rx_read || evt.rx_empty) begin
				rx_timeout <= 1'b0;
			end
		end
	end

	// Checks
	irq_pin_a: assert property (|pend |=> !irq_n) else $error("pending source did not pull irq low");
	idle_code_a: assert property (pend == 7'h00 |-> iir_v == IIR_NONE) else $error("idle code wrong");
	ls_prio_a: assert property (pend[0] |-> iir_v == IIR_LS) else $error("line status not top priority");
	brk_force_a: assert property (wr && paddr == A_LCR && pwdata[6] |=> tx_force_low) else $error("break not forced");
	zero_div_a: assert property (divisor == 16'h0000 |=> !sample_tick) else $error("tick with zero divisor");
	sleep_perm_a: assert property ($rose(sleep_q) |-> $past(allowed)) else $error("sleep without enables");
	sleep_cond_a: assert property ($rose(sleep_q) |-> $past(evt.rx_empty && evt.tx_idle)) else $error("sleep too early");
	tx_wake_a: assert property (sleep_q && evt.tx_write |=> !sleep_q) else $error("no wake on write");
	head_zero_a: assert property (setup && !pwrite && paddr == A_LSR && evt.rx_empty
		|=> prdata[4:2] == 3'h0) else $error("head flags not zero when empty");
	spc_clr_a: assert property (spc_q && iir_rd && !evt.special_det |=> !spc_q) else $error("special flag kept");
	// Priority codes below the top source
	to_code_a: assert property (pend[1] && rx_timeout && !pend[0] |-> iir_v == IIR_TO)
		else $error("time-out code wrong");
	rx_code_a: assert property (pend[1] && !rx_timeout && !pend[0] |-> iir_v == IIR_RX)
		else $error("data ready code wrong");
	tx_code_a: assert property (pend[2:0] == 3'h4 |-> iir_v == IIR_TX)
		else $error("transmit code wrong");
	io_code_a: assert property (pend[4:0] == 5'h10 |-> iir_v == IIR_IO)
		else $error("pin change code wrong");
	rc_code_a: assert property (pend == 7'h40 |-> iir_v == IIR_RC)
		else $error("pin release code wrong");
	// Flags, polled mode, break, sleep and time-out
	ovr_set_a: assert property (evt.rx_overrun |=> ovr_q)
		else $error("overrun not recorded");
	xoff_hold_a: assert property (xoff_q && !evt.xon_det |=> xoff_q)
		else $error("stop flag lost without resume");
	poll_quiet_a: assert property (ier_q[3:0] == 4'h0 && ier_q[6:5] == 2'h0 && ioen_q == 8'h00 |=> irq_n)
		else $error("irq low in polled mode");
	brk_once_a: assert property (break_det |=> !break_det)
		else $error("break pulse too long");
	sleep_tick_a: assert property (sleep_q |=> !sample_tick)
		else $error("baud tick while asleep");
	rx_wake_a: assert property (sleep_q && rx_pin != rx_prev_q |=> !sleep_q)
		else $error("no wake on line change");
	to_restart_a: assert property (evt.rx_read |=> !rx_timeout)
		else $error("time-out kept after read");
endmodule // uis_core
`default_nettype wire

// *** sim/uis_host.sv ***
// Host model: APB master reaching the channel registers
`default_nettype none
module uis_host (
	input wire logic core_clk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ns;
	logic hung = 1'b0;
	logic err = 1'b0;
	// Bus idle at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	// One transfer; callers touch the divisor only while awake
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		hung = hung | (n >= 50);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule // uis_host
`default_nettype wire

// *** sim/uis_core_bench.sv ***
// Testbench of the channel interrupt, sleep and baud block
`default_nettype none
module uis_core_bench;
	import uis_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, irq_n, tx_force_low;
	logic sample_tick, bit_tick, chan_clk_en, break_det, rx_timeout;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	uis_evt_s evt = '0;
	uis_evt_s quiet = '{rx_empty: 1'b1, tx_idle: 1'b1, default: '0};
	logic rx_pin = 1'b1;
	logic cts_n = 1'b1;
	logic rts_n = 1'b1;
	logic [7:0] io_pins = 8'h00;
	int n_mismatch = 0;
	int checks_done = 0;
	int n;
	always #50 core_clk = ~core_clk;
	uis_host host (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	uis_core uut (.core_clk(core_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
		.rx_pin(rx_pin), .rts_n(rts_n), .cts_n(cts_n), .io_pins(io_pins), .irq_n(irq_n),
		.tx_force_low(tx_force_low), .sample_tick(sample_tick), .bit_tick(bit_tick),
		.chan_clk_en(chan_clk_en), .break_det(break_det), .rx_timeout(rx_timeout));
	// Verdict and end of run
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Register access; a hung bus ends the run
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
		host.xfer(w, a, d, q);
		if (host.hung) begin
			n_mismatch++;
			stop_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	// Masked read compare; upper bits must read zero
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q & {24'hFF_FFFF, m}, {24'h00_0000, e});
	endtask
	// Raise event bits for one cycle
	task automatic pulse(input uis_evt_s p);
		@(posedge core_clk);
		evt <= uis_evt_s'(evt | p);
		@(posedge core_clk);
		evt <= uis_evt_s'(evt & ~p);
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return sample_tick;
			1: return bit_tick;
			2: return break_det;
			3: return rx_timeout;
			4: return ~chan_clk_en;
			default: return chan_clk_en;
		endcase
	endfunction
	// Cycles until the chosen output is high, bounded
	task automatic wt(input int s, output int c);
		c = 0;
		do begin
			@(posedge core_clk);
			c++;
		end while (sig(s) !== 1'b1 && c < 5000);
		if (c >= 5000) begin
			n_mismatch++;
			stop_test();
		end
	endtask
	task automatic gap(input int s, input int e);
		wt(s, n);
		wt(s, n);
		wt(s, n);
		chk(n, e);
	endtask
	// Reset values; kept registers survive a second reset
	task automatic t_reset;
		rd(A_IIR, {2'b00, IIR_NONE}, 8'hFF);
		rd(A_LCR, LCR_RST, 8'hFF);
		rd(8'h30, 8'h00, 8'hFF);
		chk(host.err, 1'b1);
		rd(A_MCR, 8'h00, 8'h80);
		chk(host.err, 1'b0);
		wr(A_SPR, 8'h5A);
		wr(A_DLL, 8'h02);
		wr(A_DLH, 8'h00);
		@(posedge core_clk) rstn <= 1'b0;
		@(posedge core_clk) rstn <= 1'b1;
		rd(A_SPR, 8'h5A, 8'hFF);
		rd(A_DLL, 8'h02, 8'hFF);
		chk(irq_n, 1'b1);
	endtask
	// Priorities of stacked sources, pin, status and polled mode
	task automatic t_irq;
		wr(A_IER, 8'h4F);
		evt <= '{tx_ready: 1'b1, modem_delta: 1'b1, rx_empty: 1'b1, tx_idle: 1'b1, default: '0};
		rd(A_IIR, {2'b00, IIR_TX}, 8'hFF);
		chk(irq_n, 1'b0);
		evt.rx_ready <= 1'b1;
		rd(A_IIR, {2'b00, IIR_RX}, 8'hFF);
		evt.rx_err_any <= 1'b1;
		rd(A_IIR, {2'b00, IIR_LS}, 8'hFF);
		rd(A_LSR, 8'h80, 8'h80);
		evt <= '{modem_delta: 1'b1, head_flags: 3'b101, rx_empty: 1'b0, tx_idle: 1'b1, default: '0};
		rd(A_IIR, {2'b00, IIR_MDM}, 8'hFF);
		rd(A_LSR, 8'h14, 8'h9C);
		evt <= '{head_flags: 3'b101, rx_empty: 1'b1, tx_idle: 1'b1, default: '0};
		rd(A_LSR, 8'h00, 8'h1C);
		pulse('{rx_overrun: 1'b1, default: '0});
		rd(A_IIR, {2'b00, IIR_LS}, 8'hFF);
		rd(A_LSR, 8'h02, 8'h02);
		rd(A_LSR, 8'h00, 8'h02);
		wr(A_IOEN, 8'h01);
		io_pins <= 8'h01;
		rd(A_IIR, {2'b00, IIR_IO}, 8'hFF);
		rd(A_IOST, 8'h01, 8'h01);
		@(posedge core_clk) cts_n <= 1'b0;
		@(posedge core_clk) cts_n <= 1'b1;
		rd(A_IIR, {2'b00, IIR_RC}, 8'hFF);
		rd(A_IIR, {2'b00, IIR_NONE}, 8'hFF);
		@(posedge core_clk) rts_n <= 1'b0;
		@(posedge core_clk) rts_n <= 1'b1;
		rd(A_IIR, {2'b00, IIR_RC}, 8'hFF);
		evt.tx_ready <= 1'b1;
		wr(A_IER, 8'h00);
		repeat (2) @(posedge core_clk);
		chk(irq_n, 1'b1);
		evt <= quiet;
	endtask
	// Stop character versus special character clearing
	task automatic t_xoff;
		wr(A_IER, 8'h20);
		pulse('{xoff_det: 1'b1, default: '0});
		rd(A_IIR, {2'b00, IIR_XOFF}, 8'hFF);
		rd(A_IIR, {2'b00, IIR_XOFF}, 8'hFF);
		pulse('{xon_det: 1'b1, default: '0});
		rd(A_IIR, {2'b00, IIR_NONE}, 8'hFF);
		pulse('{special_det: 1'b1, default: '0});
		rd(A_IIR, {2'b00, IIR_XOFF}, 8'hFF);
		rd(A_IIR, {2'b00, IIR_NONE}, 8'hFF);
		wr(A_IER, 8'h00);
	endtask
	// Divisor, prescaler and sample rate spacing
	task automatic t_baud;
		gap(0, 2);
		gap(1, 32);
		wr(A_MCR, 8'h80);
		gap(0, 8);
		wr(A_SMP, 8'h21);
		gap(1, 136);
		wr(A_MCR, 8'h00);
		wr(A_SMP, 8'h00);
		wr(A_DLL, 8'h00);
		@(posedge core_clk);
		n = 0;
		repeat (60) begin
			@(posedge core_clk);
			if (sample_tick !== 1'b0) n++;
		end
		chk(n, 0);
		wr(A_DLL, 8'h02);
	endtask
	// Forced break, break detection and receive time-out
	task automatic t_line;
		wr(A_LCR, 8'h5D);
		@(posedge core_clk);
		chk(tx_force_low, 1'b1);
		wr(A_LCR, LCR_RST);
		@(posedge core_clk);
		chk(tx_force_low, 1'b0);
		rx_pin <= 1'b0;
		wt(2, n);
		chk(n >= 320 && n <= 384, 1'b1);
		rx_pin <= 1'b1;
		evt <= '{rx_below_trig: 1'b1, tx_idle: 1'b1, default: '0};
		wt(3, n);
		chk(n >= 1248 && n <= 1312, 1'b1);
		wr(A_IER, 8'h01);
		rd(A_IIR, {2'b00, IIR_TO}, 8'hFF);
		chk(irq_n, 1'b0);
		pulse('{rx_read: 1'b1, default: '0});
		@(posedge core_clk);
		chk(rx_timeout, 1'b0);
		wr(A_IER, 8'h00);
		evt <= quiet;
	endtask
	// Sleep gating and wake-up sources
	task automatic t_sleep;
		evt.tx_ready <= 1'b1;
		wr(A_IER, 8'h12);
		repeat (10) @(posedge core_clk);
		chk(chan_clk_en, 1'b1);
		wr(A_EFR, 8'h10);
		wt(4, n);
		chk(n < 10, 1'b1);
		pulse('{tx_write: 1'b1, default: '0});
		wt(5, n);
		chk(n < 5, 1'b1);
		wt(4, n);
		rx_pin <= 1'b0;
		wt(5, n);
		chk(n < 5, 1'b1);
		rx_pin <= 1'b1;
		wr(A_IER, 8'h00);
	endtask
	// Main sequence
	initial begin
		evt = quiet;
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		t_reset();
		t_irq();
		t_xoff();
		t_baud();
		t_line();
		t_sleep();
		stop_test();
	end
endmodule // uis_core_bench
`default_nettype wire
